// [hdl/bwss_pkg.sv]
// Purpose: constants for the bridge I/O window and secondary status block
// Assumes: AXI4-Lite register access, 32-bit data, 10 MHz core_clk
// Notes: byte offsets are the printed configuration offsets
package bwss_pkg;
   localparam logic [7:0] BWSS_OFF_BUS_LAT = 8'h18;
   localparam logic [7:0] BWSS_OFF_IO_STAT = 8'h1C;
   localparam logic [7:0] BWSS_OFF_IO_UPPER = 8'h30;
   localparam logic [7:0] BWSS_OFF_CTRL = 8'h3C;
   localparam logic [7:0] BWSS_OFF_IRQ_MASK = 8'h40;
   localparam logic [3:0] BWSS_IO_CAP_32 = 4'h1;
   localparam logic [3:0] BWSS_IO_NIB_RST = 4'h0;
   localparam logic [7:0] BWSS_SEC_LAT_VAL = 8'h00;
   localparam logic [11:0] BWSS_IO_LOW_TOP = 12'hFFF;
   localparam logic [11:0] BWSS_IO_LOW_BOT = 12'h000;
   localparam logic [15:0] BWSS_UPPER_RST = 16'h0000;
   // status bit positions within the 1Ch dword
   localparam int BWSS_BIT_PARITY = 24;
   localparam int BWSS_BIT_SIG_ABT = 27;
   localparam int BWSS_BIT_RCV_ABT = 28;
   localparam int BWSS_BIT_RCV_UR = 29;
   localparam int BWSS_BIT_SYS_ERR = 30;
   localparam int BWSS_BIT_POISON = 31;
   // control register fields, interrupt mask reset and AXI response codes
   localparam int BWSS_CTL_PERR_EN = 0;
   localparam int BWSS_CTL_SERR_EN = 1;
   localparam logic [1:0] BWSS_CTL_RST = 2'h0;
   localparam logic [5:0] BWSS_MASK_RST = 6'h00;
   localparam logic [1:0] BWSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] BWSS_RESP_SLVERR = 2'h2;
endpackage : bwss_pkg

// [hdl/bwss_regs.sv]
// Purpose: I/O window, secondary latency and secondary status registers
// Assumes: one outstanding write and one outstanding read on AXI4-Lite
// Notes: event inputs are one-cycle pulses from core_clk logic
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module bwss_regs
   import bwss_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ev_parity_err,
   input wire logic ev_cpl_abort_sent,
   input wire logic ev_cpl_abort_rcvd,
   input wire logic ev_cpl_ur_rcvd,
   input wire logic ev_err_msg_sent,
   input wire logic ev_poison_rcvd,
   input wire logic [31:0] io_addr,
   output logic io_forward,
   output logic [31:0] io_window_bottom,
   output logic [31:0] io_window_top,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] io_base;
      logic [3:0] io_limit;
      logic [15:0] base_upper;
      logic [15:0] limit_upper;
      logic [1:0] ctrl;
      logic [5:0] mask;
      logic [5:0] flags;
      logic fwd;
   } bwss_state_type;

   bwss_state_type state_reg;
   bwss_state_type state_next;

   // known offset check used by both read and write paths
   function automatic logic bwss_mapped(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      if (a == BWSS_OFF_BUS_LAT) begin
         ok = 1'b1;
      end else if (a == BWSS_OFF_IO_STAT) begin
         ok = 1'b1;
      end else if (a == BWSS_OFF_IO_UPPER) begin
         ok = 1'b1;
      end else if (a == BWSS_OFF_CTRL) begin
         ok = 1'b1;
      end else if (a == BWSS_OFF_IRQ_MASK) begin
         ok = 1'b1;
      end
      return ok;
   endfunction : bwss_mapped

   logic [5:0] ev_vec;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic do_write;
   logic [5:0] clr_vec;

   assign ev_vec = {ev_poison_rcvd, ev_err_msg_sent, ev_cpl_ur_rcvd, ev_cpl_abort_rcvd,
                    ev_cpl_abort_sent, ev_parity_err};
   assign do_write = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;

   ////////////////////////////////////////////////////////////////////////////
   // window assembly
   assign io_window_bottom = {state_reg.base_upper, state_reg.io_base, BWSS_IO_LOW_BOT};
   assign io_window_top = {state_reg.limit_upper, state_reg.io_limit, BWSS_IO_LOW_TOP};

   // fixed fields; flags [5:0] map to bits 31:24 except 26:25
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[3:0] = BWSS_IO_CAP_32;
      status_word[7:4] = state_reg.io_base;
      status_word[11:8] = BWSS_IO_CAP_32;
      status_word[15:12] = state_reg.io_limit;
      status_word[BWSS_BIT_PARITY] = state_reg.flags[0];
      status_word[BWSS_BIT_SIG_ABT] = state_reg.flags[1];
      status_word[BWSS_BIT_RCV_ABT] = state_reg.flags[2];
      status_word[BWSS_BIT_RCV_UR] = state_reg.flags[3];
      status_word[BWSS_BIT_SYS_ERR] = state_reg.flags[4];
      status_word[BWSS_BIT_POISON] = state_reg.flags[5];
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (s_axi_araddr == BWSS_OFF_BUS_LAT) begin
         rd_word = {BWSS_SEC_LAT_VAL, 24'h00_0000};
      end else if (s_axi_araddr == BWSS_OFF_IO_STAT) begin
         rd_word = status_word;
      end else if (s_axi_araddr == BWSS_OFF_IO_UPPER) begin
         rd_word = {state_reg.limit_upper, state_reg.base_upper};
      end else if (s_axi_araddr == BWSS_OFF_CTRL) begin
         rd_word = {30'h0000_0000, state_reg.ctrl};
      end else if (s_axi_araddr == BWSS_OFF_IRQ_MASK) begin
         rd_word = {26'h000_0000, state_reg.mask};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      clr_vec = 6'h00;
      if (s_axi_awvalid && s_axi_awready) begin
         state_next.aw_got = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         state_next.w_got = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         state_next.aw_got = 1'b0;
         state_next.w_got = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = bwss_mapped(state_reg.aw_addr) ? BWSS_RESP_OKAY : BWSS_RESP_SLVERR;
         if (state_reg.aw_addr == BWSS_OFF_IO_STAT) begin
            if (state_reg.w_strb[0]) begin
               state_next.io_base = state_reg.w_data[7:4];
            end
            if (state_reg.w_strb[1]) begin
               state_next.io_limit = state_reg.w_data[15:12];
            end
            if (state_reg.w_strb[3]) begin
               clr_vec[0] = state_reg.w_data[BWSS_BIT_PARITY];
               clr_vec[4] = state_reg.w_data[BWSS_BIT_SYS_ERR];
               clr_vec[5] = state_reg.w_data[BWSS_BIT_POISON];
            end
         end else if (state_reg.aw_addr == BWSS_OFF_IO_UPPER) begin
            if (state_reg.w_strb[0]) begin
               state_next.base_upper[7:0] = state_reg.w_data[7:0];
            end
            if (state_reg.w_strb[1]) begin
               state_next.base_upper[15:8] = state_reg.w_data[15:8];
            end
            if (state_reg.w_strb[2]) begin
               state_next.limit_upper[7:0] = state_reg.w_data[23:16];
            end
            if (state_reg.w_strb[3]) begin
               state_next.limit_upper[15:8] = state_reg.w_data[31:24];
            end
         end else if (state_reg.aw_addr == BWSS_OFF_CTRL) begin
            if (state_reg.w_strb[0]) begin
               state_next.ctrl = state_reg.w_data[1:0];
            end
         end else if (state_reg.aw_addr == BWSS_OFF_IRQ_MASK) begin
            if (state_reg.w_strb[0]) begin
               state_next.mask = state_reg.w_data[5:0];
            end
         end
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = rd_word;
         state_next.rresp = bwss_mapped(s_axi_araddr) ? BWSS_RESP_OKAY : BWSS_RESP_SLVERR;
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
      // set wins, clear applied first; RO flags are never cleared by software
      state_next.flags = state_reg.flags & ~clr_vec;
      if (ev_vec[0] && state_reg.ctrl[BWSS_CTL_PERR_EN]) begin
         state_next.flags[0] = 1'b1;
      end
      state_next.flags[3:1] = state_next.flags[3:1] | ev_vec[3:1];
      if (ev_vec[4] && state_reg.ctrl[BWSS_CTL_SERR_EN]) begin
         state_next.flags[4] = 1'b1;
      end
      if (ev_vec[5]) begin
         state_next.flags[5] = 1'b1;
      end
      // inclusive window compare, registered
      // registered to keep two 32-bit compares off the output; lags io_addr one cycle
      state_next.fwd = (io_addr >= io_window_bottom) && (io_addr <= io_window_top);
      if (!rst_n) begin
         state_next = '0;
         state_next.io_base = BWSS_IO_NIB_RST;
         state_next.io_limit = BWSS_IO_NIB_RST;
         state_next.base_upper = BWSS_UPPER_RST;
         state_next.limit_upper = BWSS_UPPER_RST;
         state_next.ctrl = BWSS_CTL_RST;
         state_next.mask = BWSS_MASK_RST;
      end
   end

   always_ff @(posedge core_clk) begin
      state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
   assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign io_forward = state_reg.fwd;
   // one level interrupt; status flags stay sticky regardless of mask
   assign irq = |(state_reg.flags & state_reg.mask);

   ////////////////////////////////////////////////////////////////////////////
   // latency byte zero
   chk_lat_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == BWSS_OFF_BUS_LAT)
      |=> s_axi_rdata[31:24] == 8'h00) else $error("latency byte not zero");
   chk_cap_nibble: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == BWSS_OFF_IO_STAT)
      |=> s_axi_rdata[3:0] == 4'h1 && s_axi_rdata[11:8] == 4'h1)
      else $error("io capability nibble wrong");
   chk_fixed_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == BWSS_OFF_IO_STAT)
      |=> s_axi_rdata[21] == 1'b0 && s_axi_rdata[23] == 1'b0 && s_axi_rdata[26:25] == 2'h0)
      else $error("fixed status bits nonzero");
   chk_window_bot: assert property (@(posedge core_clk) disable iff (!rst_n)
      io_window_bottom[11:0] == 12'h000 && io_window_bottom[15:12] == state_reg.io_base)
      else $error("window bottom wrong");
   chk_window_top: assert property (@(posedge core_clk) disable iff (!rst_n)
      io_window_top[11:0] == 12'hFFF && io_window_top[15:12] == state_reg.io_limit)
      else $error("window top wrong");
   chk_base_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && state_reg.aw_addr == BWSS_OFF_IO_STAT && state_reg.w_strb[0])
      |=> io_window_bottom[15:12] == $past(state_reg.w_data[7:4]))
      else $error("io base nibble not written");
   chk_limit_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && state_reg.aw_addr == BWSS_OFF_IO_STAT && state_reg.w_strb[1])
      |=> io_window_top[15:12] == $past(state_reg.w_data[15:12]))
      else $error("io limit nibble not written");
   chk_upper_half: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && state_reg.aw_addr == BWSS_OFF_IO_UPPER && state_reg.w_strb == 4'hF)
      |=> io_window_bottom[31:16] == $past(state_reg.w_data[15:0])
      && io_window_top[31:16] == $past(state_reg.w_data[31:16]))
      else $error("window upper half wrong");
   chk_fwd_match: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> io_forward == ($past(io_addr) >= $past(io_window_bottom)
      && $past(io_addr) <= $past(io_window_top)))
      else $error("forward decision wrong");
   chk_parity_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ev_parity_err && state_reg.ctrl[BWSS_CTL_PERR_EN]) |=> state_reg.flags[0])
      else $error("parity flag missed");
   chk_parity_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!state_reg.flags[0] && !state_reg.ctrl[BWSS_CTL_PERR_EN]) |=> !state_reg.flags[0])
      else $error("parity flag set while disabled");
   chk_abort_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev_cpl_abort_sent |=> state_reg.flags[1]) else $error("abort flag missed");
   chk_rabt_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev_cpl_abort_rcvd |=> state_reg.flags[2]) else $error("received abort flag missed");
   chk_ur_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev_cpl_ur_rcvd |=> state_reg.flags[3]) else $error("unsupported flag missed");
   chk_serr_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ev_err_msg_sent && state_reg.ctrl[BWSS_CTL_SERR_EN]) |=> state_reg.flags[4])
      else $error("system error flag missed");
   chk_serr_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!state_reg.flags[4] && !state_reg.ctrl[BWSS_CTL_SERR_EN]) |=> !state_reg.flags[4])
      else $error("system error flag set while disabled");
   chk_poison_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev_poison_rcvd |=> state_reg.flags[5]) else $error("poison flag lost");
   chk_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && state_reg.aw_addr == BWSS_OFF_IO_STAT && state_reg.w_strb[3]
       && state_reg.w_data[BWSS_BIT_POISON] && !ev_poison_rcvd) |=> !state_reg.flags[5])
      else $error("poison flag not cleared");
   chk_w1c_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && state_reg.aw_addr == BWSS_OFF_IO_STAT && state_reg.flags[0]
       && !state_reg.w_data[BWSS_BIT_PARITY]) |=> state_reg.flags[0])
      else $error("parity flag lost on zero write");
   chk_ro_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) |-> (state_reg.flags[3:1] & $past(state_reg.flags[3:1]))
      == $past(state_reg.flags[3:1])) else $error("read-only flag dropped");
   // unmapped offsets answer with an error and no data
   chk_slverr_rd: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && !bwss_mapped(s_axi_araddr))
      |=> s_axi_rresp == BWSS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_slverr_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_write && !bwss_mapped(state_reg.aw_addr)) |=> s_axi_bresp == BWSS_RESP_SLVERR)
      else $error("unmapped write not refused");
   // response follows the request by one cycle
   chk_b_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      do_write |=> s_axi_bvalid) else $error("write response missing");
   chk_r_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read response missing");
   // main scenarios
   cov_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      s_axi_bvalid && s_axi_bready);
   cov_read: cover property (@(posedge core_clk) disable iff (!rst_n)
      s_axi_rvalid && s_axi_rready);
   cov_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));
   cov_fwd: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(io_forward));
   cov_set_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
      ev_poison_rcvd && do_write && clr_vec[5]);

endmodule : bwss_regs
`default_nettype wire

// [test/bwss_tb.sv]
// Purpose: self-checking bench for the I/O window and secondary status block
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: event inputs pulse one cycle; expected values follow the register map
`timescale 1ns/10ps
`default_nettype none
module bridge_io_window_secondary_status_tb
   import bwss_pkg::*;
;
logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, io_addr, s_axi_rdata, io_window_bottom, io_window_top;
logic [3:0] s_axi_wstrb;
logic [5:0] ev;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_forward, irq;
logic [1:0] s_axi_bresp, s_axi_rresp;
int error_cnt, checks_done, cycles;
logic [31:0] fa [5] = '{32'h0001_2FFF, 32'h0001_3000, 32'h0002_5FFF, 32'h0002_6000, 32'h0003_4000};
logic fe [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

bwss_regs u_bwss_regs (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .ev_parity_err(ev[0]), .ev_cpl_abort_sent(ev[1]),
   .ev_cpl_abort_rcvd(ev[2]), .ev_cpl_ur_rcvd(ev[3]), .ev_err_msg_sent(ev[4]),
   .ev_poison_rcvd(ev[5]), .io_addr(io_addr), .io_forward(io_forward),
   .io_window_bottom(io_window_bottom), .io_window_top(io_window_top), .irq(irq));

////////////////////////////////////////////////////////////
task automatic tally_and_finish();
   $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
   if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
   end else begin
      $display("STATUS NOT OK");
   end
   $finish;
endtask : tally_and_finish

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   checks_done++;
   if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
   end
endtask : check

task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
   input logic [1:0] er);
   bit aw_ok = 1'b0;
   bit w_ok = 1'b0;
   s_axi_awaddr <= a;
   s_axi_wdata <= d;
   s_axi_wstrb <= s;
   s_axi_awvalid <= 1'b1;
   s_axi_wvalid <= 1'b1;
   s_axi_bready <= 1'b1;
   while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
         aw_ok = 1'b1;
         s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
         w_ok = 1'b1;
         s_axi_wvalid <= 1'b0;
      end
   end
   do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
   check({30'h0, s_axi_bresp}, {30'h0, er});
   s_axi_bready <= 1'b0;
   // idle edge so a following call never raises bready in the same step
   @(posedge core_clk);
endtask : axi_wr

task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
   s_axi_araddr <= a;
   s_axi_arvalid <= 1'b1;
   s_axi_rready <= 1'b1;
   do @(posedge core_clk); while (s_axi_arready !== 1'b1);
   s_axi_arvalid <= 1'b0;
   do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
   check(s_axi_rdata, ed);
   check({30'h0, s_axi_rresp}, {30'h0, er});
   s_axi_rready <= 1'b0;
   @(posedge core_clk);
endtask : axi_rd

task automatic pulse(input int idx);
   ev <= 6'h01 << idx;
   @(posedge core_clk);
   ev <= 6'h00;
   @(posedge core_clk);
endtask : pulse

// io_forward lags io_addr by one edge; three edges leave margin
task automatic fwd(input logic [31:0] a, input logic e);
   io_addr <= a;
   repeat (3) @(posedge core_clk);
   check({31'h0, io_forward}, {31'h0, e});
endtask : fwd

task automatic do_reset();
   rst_n <= 1'b0;
   repeat (6) @(posedge core_clk);
   rst_n <= 1'b1;
   @(posedge core_clk);
endtask : do_reset

////////////////////////////////////////////////////////////
initial begin
   core_clk = 1'b0;
   forever #50 core_clk = ~core_clk;
end

// a hang anywhere ends the run with a mismatch rather than silence
always @(posedge core_clk) begin
   cycles++;
   if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
   end
end

initial begin
   {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ev, io_addr} = '0;
   do_reset();
   axi_rd(BWSS_OFF_BUS_LAT, 32'h0000_0000, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IO_STAT, 32'h0000_0101, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IRQ_MASK, 32'h0000_0000, BWSS_RESP_OKAY);
   check(io_window_top, 32'h0000_0FFF);
   check({31'h0, irq}, 32'h0);
   $display("test reset_values done");
   axi_wr(BWSS_OFF_BUS_LAT, 32'hFFFF_FFFF, 4'hF, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_BUS_LAT, 32'h0000_0000, BWSS_RESP_OKAY);
   axi_wr(BWSS_OFF_IO_STAT, 32'hFFFF_FFFF, 4'hF, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IO_STAT, 32'h0000_F1F1, BWSS_RESP_OKAY);
   axi_wr(BWSS_OFF_IO_STAT, 32'h0000_0000, 4'h2, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IO_STAT, 32'h0000_01F1, BWSS_RESP_OKAY);
   $display("test field_access done");
   axi_wr(BWSS_OFF_IO_UPPER, 32'h0002_0001, 4'hF, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IO_UPPER, 32'h0002_0001, BWSS_RESP_OKAY);
   axi_wr(BWSS_OFF_IO_STAT, 32'h0000_5030, 4'h3, BWSS_RESP_OKAY);
   check(io_window_bottom, 32'h0001_3000);
   check(io_window_top, 32'h0002_5FFF);
   for (int i = 0; i < 5; i++) begin
      fwd(fa[i], fe[i]);
   end
   $display("test io_window done");
   pulse(0);
   pulse(4);
   axi_rd(BWSS_OFF_IO_STAT, 32'h0000_5131, BWSS_RESP_OKAY);
   axi_wr(BWSS_OFF_CTRL, 32'h0000_0003, 4'hF, BWSS_RESP_OKAY);
   for (int i = 0; i < 6; i++) begin
      pulse(i);
   end
   axi_rd(BWSS_OFF_IO_STAT, 32'hF900_5131, BWSS_RESP_OKAY);
   // poison arrives in the cycle the clear lands; zero bits leave 24 and 30 alone
   fork
      axi_wr(BWSS_OFF_IO_STAT, 32'h8000_0000, 4'h8, BWSS_RESP_OKAY);
      begin
         @(posedge core_clk);
         ev <= 6'h20;
         @(posedge core_clk);
         ev <= 6'h00;
      end
   join
   axi_rd(BWSS_OFF_IO_STAT, 32'hF900_5131, BWSS_RESP_OKAY);
   axi_wr(BWSS_OFF_IO_STAT, 32'hFF00_0000, 4'h8, BWSS_RESP_OKAY);
   axi_rd(BWSS_OFF_IO_STAT, 32'h3800_5131, BWSS_RESP_OKAY);
   $display("test status_flags done");
   check({31'h0, irq}, 32'h0);
   axi_wr(BWSS_OFF_IRQ_MASK, 32'h0000_0001, 4'hF, BWSS_RESP_OKAY);
   check({31'h0, irq}, 32'h0);
   pulse(0);
   check({31'h0, irq}, 32'h1);
   axi_wr(BWSS_OFF_IO_STAT, 32'h0100_0000, 4'h8, BWSS_RESP_OKAY);
   check({31'h0, irq}, 32'h0);
   axi_wr(BWSS_OFF_IRQ_MASK, 32'h0000_0002, 4'hF, BWSS_RESP_OKAY);
   check({31'h0, irq}, 32'h1);
   $display("test interrupt done");
   axi_wr(8'h44, 32'hFFFF_FFFF, 4'hF, BWSS_RESP_SLVERR);
   axi_rd(8'h44, 32'h0000_0000, BWSS_RESP_SLVERR);
   $display("test unmapped done");
   do_reset();
   axi_rd(BWSS_OFF_IO_STAT, 32'h0000_0101, BWSS_RESP_OKAY);
   check(io_window_bottom, 32'h0000_0000);
   check({31'h0, irq}, 32'h0);
   $display("test second_reset done");
   tally_and_finish();
end
endmodule : bridge_io_window_secondary_status_tb
`default_nettype wire
